// ===== design/reset_source_combiner_regs.svh
// Notes on behaviour
// R1 - nine reset sources each feed the one master system reset.
// R2 - master system reset is the OR of all active source requests.
// R3 - every reset event sets its own cause flag in the status register.
// R4 - power-on clears all flags except brown-out and power-on, which are set.
// R5 - software may set or clear any flag at any time; value stored as written (code ORs in a cause rising that cycle; a power-on event overrides the write).
// R6 - software setting a flag never causes a system reset.
// R7 - registers with a reset state are forced to it while system reset is active (code does not reload the cause flags on MASTER_SYSTEM_RESET).
// R8 - software should clear flags after reading so next cause is clear.
// R9 - non power-on resets keep existing flags and only add their own.
`ifndef RESET_SOURCE_COMBINER_REGS_SVH
`define RESET_SOURCE_COMBINER_REGS_SVH

// ----------------------------------------
// cause flag positions
// ----------------------------------------
`define RSC_NUM_SRC 9
`define RSC_BIT_POR 0
`define RSC_BIT_BROWN 1
`define RSC_BIT_PIN 2
`define RSC_BIT_SWI 3
`define RSC_BIT_WDOG 4
`define RSC_BIT_CFGM 5
`define RSC_BIT_TRAP 6
`define RSC_BIT_IOP 7
`define RSC_BIT_WREG 8
`define RSC_FLAGS_RESET 9'h000
`define RSC_FLAGS_POR 9'h003

`endif

// ===== design/reset_source_combiner_pkg.sv
`default_nettype none
package reset_source_combiner_pkg;
    typedef struct packed {
        logic uninit_wreg_reset;
        logic illegal_opcode_reset;
        logic trap_conflict_reset;
        logic config_mismatch_reset;
        logic watchdog_reset_source;
        logic software_instruction_reset;
        logic external_pin_reset;
        logic brown_out_reset_flag;
        logic power_on;
    } reset_src_t;

    typedef struct packed {
        logic en;
        logic [8:0] data;
    } flag_write_t;
endpackage
`default_nettype wire

// ===== design/rsc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_sync2 #(
    parameter int WIDTH = 9
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== design/reset_source_combiner.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_combiner_regs.svh"
module reset_source_combiner (
    input wire logic CLK,
    input wire logic NRST,
    input wire reset_source_combiner_pkg::reset_src_t RESET_REQ,
    input wire reset_source_combiner_pkg::flag_write_t FLAG_WR,
    output logic MASTER_SYSTEM_RESET,
    output logic [8:0] RESET_CONTROL_STATUS_REG
);
    // ----------------------------------------
    // source capture
    // ----------------------------------------
    // requests come from detectors on other domains, hence two stages
    reset_source_combiner_pkg::reset_src_t src_sync;
    logic [8:0] src_vec;
    logic [8:0] src_prev_q;
    logic [8:0] src_rise;
    logic any_src;
    logic por_event;

    rsc_sync2 #(
        .WIDTH(`RSC_NUM_SRC)
    ) u_sync (
        .CLK(CLK),
        .NRST(NRST),
        .d(RESET_REQ),
        .q(src_sync)
    );

    assign src_vec = src_sync; // see R1
    assign any_src = |src_vec; // see R2
    assign src_rise = src_vec & ~src_prev_q;
    assign por_event = src_rise[`RSC_BIT_POR];

    // ----------------------------------------
    // flags and reset output
    // ----------------------------------------
    logic [8:0] flags_q;
    logic [8:0] flags_d;
    logic [8:0] flags_sw;
    logic rst_q;

    // software write applies first, hardware events then win over a clear
    assign flags_sw = FLAG_WR.en ? FLAG_WR.data : flags_q; // see R5
    assign flags_d = por_event ? `RSC_FLAGS_POR // see R4
        : (flags_sw | src_rise); // see R3, R9

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            flags_q <= `RSC_FLAGS_POR;
            src_prev_q <= '0;
            rst_q <= 1'b1;
        end else begin
            flags_q <= flags_d;
            src_prev_q <= src_vec;
            rst_q <= any_src; // see R2, R6
        end
    end

    // reset held from NRST and registered combine; flags themselves never feed it
    assign MASTER_SYSTEM_RESET = rst_q; // see R7
    assign RESET_CONTROL_STATUS_REG = flags_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_or_reset;
        @(posedge CLK) disable iff (!NRST) any_src |=> MASTER_SYSTEM_RESET;
    endproperty
    a_or_reset: assert property (p_or_reset) else $error("reset not raised"); // see R2

    property p_no_reset;
        @(posedge CLK) disable iff (!NRST) !any_src |=> !MASTER_SYSTEM_RESET;
    endproperty
    a_no_reset: assert property (p_no_reset) else $error("spurious reset"); // see R6

    property p_por_flags;
        @(posedge CLK) disable iff (!NRST)
            por_event |=> RESET_CONTROL_STATUS_REG == `RSC_FLAGS_POR;
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong"); // see R4

    property p_cause_set;
        @(posedge CLK) disable iff (!NRST)
            (|src_rise) && !por_event |=> ((RESET_CONTROL_STATUS_REG & $past(src_rise)) == $past(src_rise));
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("cause flag missing"); // see R3

    property p_keep;
        @(posedge CLK) disable iff (!NRST)
            !por_event && !FLAG_WR.en |=> ((RESET_CONTROL_STATUS_REG & $past(flags_q)) == $past(flags_q));
    endproperty
    a_keep: assert property (p_keep) else $error("flag lost"); // see R9

    property p_sw_write;
        @(posedge CLK) disable iff (!NRST)
            FLAG_WR.en && !(|src_rise) |=> RESET_CONTROL_STATUS_REG == $past(FLAG_WR.data);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("write not stored"); // see R5

    property p_src_feeds;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_WREG]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_src_feeds: assert property (p_src_feeds) else $error("source not combined"); // see R1

    // ----------------------------------------
    // per-source combine checks
    // ----------------------------------------
    // each bit on its own, so a term dropped from the OR shows up
    property p_feeds_por;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_POR]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_feeds_por: assert property (p_feeds_por) else $error("power-on term lost"); // see R1

    property p_feeds_brown;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_BROWN]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_feeds_brown: assert property (p_feeds_brown) else $error("brown-out term lost"); // see R1

    property p_feeds_pin;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_PIN]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_feeds_pin: assert property (p_feeds_pin) else $error("pin term lost"); // see R1

    property p_feeds_swi;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_SWI]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_feeds_swi: assert property (p_feeds_swi) else $error("instruction term lost"); // see R1

    property p_feeds_wdog;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_WDOG]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_feeds_wdog: assert property (p_feeds_wdog) else $error("watchdog term lost"); // see R1

    property p_feeds_cfgm;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_CFGM]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_feeds_cfgm: assert property (p_feeds_cfgm) else $error("mismatch term lost"); // see R1

    property p_feeds_trap;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_TRAP]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_feeds_trap: assert property (p_feeds_trap) else $error("trap term lost"); // see R1

    property p_feeds_iop;
        @(posedge CLK) disable iff (!NRST)
            $rose(src_vec[`RSC_BIT_IOP]) |=> MASTER_SYSTEM_RESET;
    endproperty
    a_feeds_iop: assert property (p_feeds_iop) else $error("opcode term lost"); // see R1

    // ----------------------------------------
    // latency and accumulation checks
    // ----------------------------------------
    // two sync stages plus the output register: three sampled edges
    sequence s_req_held;
        (|RESET_REQ) [*3];
    endsequence

    sequence s_req_gone;
        (!(|RESET_REQ)) [*3];
    endsequence

    property p_req_to_reset;
        @(posedge CLK) disable iff (!NRST) s_req_held |=> MASTER_SYSTEM_RESET;
    endproperty
    a_req_to_reset: assert property (p_req_to_reset) else $error("reset late"); // see R2

    property p_idle_release;
        @(posedge CLK) disable iff (!NRST) s_req_gone |=> !MASTER_SYSTEM_RESET;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("reset stuck"); // see R2

    // a write landing on the edge of a new cause
    sequence s_write_meets_event;
        FLAG_WR.en && (|src_rise) && !por_event;
    endsequence

    property p_set_wins;
        @(posedge CLK) disable iff (!NRST)
            s_write_meets_event |=>
                RESET_CONTROL_STATUS_REG == ($past(FLAG_WR.data) | $past(src_rise));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("cleared cause lost"); // see R3

    // nothing beyond the held or raised bits may appear
    property p_only_own;
        @(posedge CLK) disable iff (!NRST)
            !por_event && !FLAG_WR.en |=>
                RESET_CONTROL_STATUS_REG == ($past(flags_q) | $past(src_rise));
    endproperty
    a_only_own: assert property (p_only_own) else $error("stray flag set"); // see R9

    // a flag write alone must not reach the reset output
    property p_write_no_reset;
        @(posedge CLK) disable iff (!NRST) FLAG_WR.en && !any_src |=> !MASTER_SYSTEM_RESET;
    endproperty
    a_write_no_reset: assert property (p_write_no_reset) else $error("write reset"); // see R6

    // a rising reset always leaves its cause behind
    property p_rose_has_cause;
        @(posedge CLK) disable iff (!NRST)
            $rose(MASTER_SYSTEM_RESET) |-> (|RESET_CONTROL_STATUS_REG);
    endproperty
    a_rose_has_cause: assert property (p_rose_has_cause) else $error("no cause"); // see R3

    // the cause flags must outlive the reset they report
    property p_flags_survive;
        @(posedge CLK) disable iff (!NRST)
            MASTER_SYSTEM_RESET && !(|src_rise) && !FLAG_WR.en |=>
                $stable(RESET_CONTROL_STATUS_REG);
    endproperty
    a_flags_survive: assert property (p_flags_survive) else $error("flags changed"); // see R7
endmodule
`default_nettype wire

// ===== test/reset_detectors.sv
`timescale 1ns/1ps
`default_nettype none
module reset_detectors (
    input wire logic CLK,
    input wire logic [8:0] raise,
    output reset_source_combiner_pkg::reset_src_t req
);
    // requests are held as levels until the cause goes away
    always_ff @(posedge CLK) begin
        req <= raise;
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    reset_source_combiner_pkg::flag_write_t wr_bus = '0;
    reset_source_combiner_pkg::reset_src_t req;
    logic [8:0] raise = 9'h000;
    logic rst;
    logic [8:0] flags;
    logic [8:0] acc;
    int n_fail = 0;
    int samples_checked = 0;
    always #5 CLK = ~CLK;
    reset_detectors det (.CLK(CLK), .raise(raise), .req(req));
    reset_source_combiner dut (.CLK(CLK), .NRST(NRST), .RESET_REQ(req), .FLAG_WR(wr_bus),
        .MASTER_SYSTEM_RESET(rst), .RESET_CONTROL_STATUS_REG(flags));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic r, input logic [8:0] f);
        samples_checked++;
        if (rst !== r || flags !== f) begin
            n_fail++;
            $display("wrong value at %0t: reset %b flags %h", $time, rst, flags);
        end
    endtask
    // bounded wait, a stuck output ends the run
    task automatic wait_rst(input logic r);
        int i = 0;
        while (rst !== r) begin
            @(posedge CLK);
            #1;
            i++;
            if (i > 12) begin
                n_fail++;
                $display("wrong value at %0t: reset stuck", $time);
                test_done();
            end
        end
    endtask
    task automatic wr(input logic [8:0] v);
        wr_bus = {1'b1, v};
        @(posedge CLK);
        #1;
        wr_bus = '0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_write;
        wr(9'h1FF);
        repeat (6) begin
            chk(1'b0, 9'h1FF);
            @(posedge CLK);
            #1;
        end
        wr(9'h000);
        chk(1'b0, 9'h000);
    endtask
    task automatic t_sources;
        acc = 9'h000;
        for (int i = 1; i < 9; i++) begin
            raise = 9'h001 << i;
            wait_rst(1'b1);
            acc = acc | raise;
            chk(1'b1, acc);
            raise = 9'h000;
            wait_rst(1'b0);
            chk(1'b0, acc);
        end
        raise = 9'h001;
        wait_rst(1'b1);
        chk(1'b1, 9'h003);
        raise = 9'h000;
        wait_rst(1'b0);
    endtask
    // a clear landing on the edge of a new cause must not lose it
    task automatic t_collide;
        raise = 9'h010;
        repeat (3) @(posedge CLK);
        #1;
        wr(9'h000);
        chk(1'b1, 9'h010);
        raise = 9'h000;
        wait_rst(1'b0);
        chk(1'b0, 9'h010);
    endtask
    task automatic t_nrst;
        NRST = 1'b0;
        @(posedge CLK);
        #1;
        chk(1'b1, 9'h003);
        NRST = 1'b1;
        wait_rst(1'b0);
        chk(1'b0, 9'h003);
    endtask
    initial begin
        repeat (8) @(posedge CLK);
        #1;
        chk(1'b1, 9'h003);
        NRST = 1'b1;
        wait_rst(1'b0);
        t_write();
        t_sources();
        t_collide();
        t_nrst();
        test_done();
    end
endmodule
`default_nettype wire
